// file: phyei_unit.sv
// Per-port event interrupt unit: mask, read-clear status and pin drive
//
// What this block does
// R1 - Mask register holds one RW enable per event, reset 0, sticky only with sticky-reset enable.
// R2 - With mask bit 15 set, interrupt pin follows status bit 15.
// R3 - Clearing mask bit 15 only stops the pin; latching continues.
// R4 - Host reads status before setting mask bit 15 to drop stale events.
// R5 - Status bits read 1 while pending; a read clears returned ones.
// R6 - Status bit 15 flags pending; bits 14..0 give the causes.
// R7 - Status bits 14..0 follow the fixed event order; bit 6 reads 0.
// R8 - Mask bits share status positions; mask bit 6 is plain RW.
// R9 - Speed and duplex change events only while autonegotiation enabled.
// R10 - Downshift event only when advertisement bits 8..5 are all set.
// R11 - No receive error event while decoding carrier extension.
// R12 - Host may set masks and poll status without using the pin.
// R13 - Sticky-reset enable keeps masks over software reset, else default.
// R14 - Summary bit sets on any enabled latched event, clears on read.
`timescale 1ns/1ps
`include "phyei_regs.svh"

module phyei_unit #(
	parameter int NUM_EVT = `PHYEI_NUM_EVT
) (
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire logic                clk_en,
	input  wire phyei_pkg::phyei_evt_t evt,
	input  wire phyei_pkg::phyei_ctl_t ctl,
	input  wire phyei_pkg::phyei_req_t req,
	output logic [15:0]              mgmt_rdata,
	output logic                     mgmt_rvalid,
	output logic                     mgmt_interrupt_pin,
	output logic                     mgmt_interrupt_pin_oe
);

	if (NUM_EVT != $bits(phyei_pkg::phyei_evt_t)) begin : g_chk
		$error("NUM_EVT must match the event struct width");
	end

	phyei_pkg::phyei_state_t st_r;
	phyei_pkg::phyei_state_t st_nxt;

	logic [NUM_EVT-1:0] raw_v;
	logic [NUM_EVT-1:0] qual_v;
	logic [NUM_EVT-1:0] set_v;
	logic [NUM_EVT-1:0] status_q;
	logic               stat_rd;
	logic               mask_wr;
	logic               stat_clr;

	assign raw_v    = NUM_EVT'(evt);
	assign stat_rd  = req.rd && (req.addr == `PHYEI_STAT_OFS);
	assign mask_wr  = req.wr && (req.addr == `PHYEI_MASK_OFS);
	assign stat_clr = stat_rd || ctl.sw_reset;

	// Event qualification by other register settings
	always_comb begin
		qual_v = raw_v;
		qual_v[`PHYEI_SPD_BIT] = raw_v[`PHYEI_SPD_BIT] && ctl.an_enable; // R9
		qual_v[`PHYEI_DPX_BIT] = raw_v[`PHYEI_DPX_BIT] && ctl.an_enable; // R9
		qual_v[`PHYEI_DSH_BIT] = raw_v[`PHYEI_DSH_BIT] && (&ctl.adv_8_5); // R10
		qual_v[`PHYEI_RXE_BIT] = raw_v[`PHYEI_RXE_BIT] && !ctl.rx_er_cext; // R11
		qual_v[`PHYEI_RSV_BIT] = 1'b0; // R7
	end

	// Only enabled events latch, pin or no pin
	assign set_v = qual_v & st_r.mask[NUM_EVT-1:0]; // R1 R8 R12

	for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt
		// Read clears whatever it returned; a same-cycle event survives
		phyei_latch u_latch (
			.core_clk (core_clk),
			.nrst     (nrst),
			.clk_en   (clk_en),
			.set      (set_v[i]),
			.clr      (stat_clr),
			.q_r      (status_q[i])
		); // R5
	end

	always_comb begin
		st_nxt        = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.pin_lvl = 1'b0;
		if (req.rd) begin
			st_nxt.rvalid = 1'b1;
			if (req.addr == `PHYEI_MASK_OFS) begin
				st_nxt.rdata = st_r.mask;
			end else if (stat_rd) begin
				st_nxt.rdata = {st_r.summary, status_q}; // R6 R7
			end else begin
				st_nxt.rdata = `PHYEI_RDATA_RST;
			end
		end
		if (mask_wr) begin
			st_nxt.mask = req.wdata; // R1 R8
		end
		if (ctl.sw_reset && !ctl.sticky_rst_en) begin
			st_nxt.mask = `PHYEI_MASK_RST; // R13
		end
		if (stat_clr) begin
			st_nxt.summary = 1'b0; // R5 R14
		end
		if (|set_v) begin
			st_nxt.summary = 1'b1; // R14
		end
		// Pin pulls low only while enabled and pending
		st_nxt.pin_oe = st_nxt.mask[`PHYEI_SUM_BIT] && st_nxt.summary; // R2 R3
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r.mask    <= `PHYEI_MASK_RST;
			st_r.summary <= 1'b0;
			st_r.rdata   <= `PHYEI_RDATA_RST;
			st_r.rvalid  <= 1'b0;
			st_r.pin_oe  <= 1'b0;
			st_r.pin_lvl <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign mgmt_rdata            = st_r.rdata;
	assign mgmt_rvalid           = st_r.rvalid;
	assign mgmt_interrupt_pin    = st_r.pin_lvl;
	assign mgmt_interrupt_pin_oe = st_r.pin_oe;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_mask_write;
		clk_en && mask_wr && !ctl.sw_reset;
	endsequence

	sequence s_quiet_read;
		clk_en && stat_rd && !(|set_v) && !ctl.sw_reset;
	endsequence

	sequence s_cleared;
		(status_q == `PHYEI_STAT_RST) && !st_r.summary;
	endsequence

	a_mask_write_store: assert property ( // R1
		s_mask_write |=> st_r.mask == $past(req.wdata))
		else $error("Mask register did not take written value");

	a_pin_follow_sum: assert property ( // R2
		clk_en && st_nxt.mask[15] && (|set_v) |=> mgmt_interrupt_pin_oe)
		else $error("Interrupt pin not driven for enabled pending event");

	a_pin_inhibit_only: assert property ( // R3
		clk_en && !st_r.mask[15] && !mask_wr && (|set_v)
		|=> !mgmt_interrupt_pin_oe && st_r.summary)
		else $error("Pin inhibit disturbed latching or pin drove");

	a_read_clears_all: assert property ( // R5
		s_quiet_read |=> s_cleared)
		else $error("Status read did not clear returned bits");

	a_read_returns_sum: assert property ( // R6
		clk_en && stat_rd |=> mgmt_rvalid
		&& mgmt_rdata == {$past(st_r.summary), $past(status_q)})
		else $error("Status read returned wrong word");

	a_rsvd_reads_zero: assert property ( // R7
		clk_en && stat_rd |=> !mgmt_rdata[`PHYEI_RSV_BIT]
		&& !status_q[`PHYEI_RSV_BIT])
		else $error("Reserved status bit set");

	a_spd_needs_an: assert property ( // R9
		$rose(status_q[`PHYEI_SPD_BIT]) |-> $past(ctl.an_enable))
		else $error("Speed change latched without autonegotiation");

	a_dsh_needs_adv: assert property ( // R10
		$rose(status_q[`PHYEI_DSH_BIT]) |-> $past(&ctl.adv_8_5))
		else $error("Downshift latched without advertisement bits");

	a_rxe_not_cext: assert property ( // R11
		$rose(status_q[`PHYEI_RXE_BIT]) |-> !$past(ctl.rx_er_cext))
		else $error("Receive error latched during carrier extension");

	a_poll_no_pin: assert property ( // R12
		clk_en && set_v[`PHYEI_LNK_BIT] |=> status_q[`PHYEI_LNK_BIT])
		else $error("Enabled link event not latched for polling");

	a_sticky_keep: assert property ( // R13
		clk_en && ctl.sw_reset && ctl.sticky_rst_en && !mask_wr
		|=> $stable(st_r.mask))
		else $error("Mask lost across sticky software reset");

	a_sticky_clear: assert property ( // R13
		clk_en && ctl.sw_reset && !ctl.sticky_rst_en
		|=> st_r.mask == `PHYEI_MASK_RST)
		else $error("Mask not defaulted by software reset");

	a_sum_sets: assert property ( // R14
		clk_en && (|set_v) |=> st_r.summary)
		else $error("Summary bit not set by enabled event");

	a_mask_read_back: assert property ( // R1
		clk_en && req.rd && (req.addr == `PHYEI_MASK_OFS)
		|=> mgmt_rvalid && mgmt_rdata == $past(st_r.mask))
		else $error("Mask read returned wrong word");

	a_masked_dropped: assert property ( // R1
		clk_en && !st_r.mask[`PHYEI_SPD_BIT] && !status_q[`PHYEI_SPD_BIT]
		|=> !status_q[`PHYEI_SPD_BIT])
		else $error("Masked speed event was latched");

	a_rsvd_mask_rw: assert property ( // R8
		s_mask_write |=> st_r.mask[`PHYEI_RSV_BIT]
		== $past(req.wdata[`PHYEI_RSV_BIT]))
		else $error("Reserved mask bit did not store");

	a_pin_drops_read: assert property ( // R2
		s_quiet_read |=> !mgmt_interrupt_pin_oe)
		else $error("Interrupt pin stayed driven after status read");

	a_pin_on_write: assert property ( // R2
		clk_en && mask_wr && req.wdata[`PHYEI_SUM_BIT] && st_r.summary
		&& !stat_clr |=> mgmt_interrupt_pin_oe)
		else $error("Pending event did not drive pin when enabled");

	a_pin_needs_enable: assert property ( // R3
		!st_r.mask[`PHYEI_SUM_BIT] |-> !mgmt_interrupt_pin_oe)
		else $error("Interrupt pin driven while disabled");

	a_swr_clears_stat: assert property ( // R13
		clk_en && ctl.sw_reset && !(|set_v) |=> s_cleared)
		else $error("Software reset left status pending");

endmodule // phyei_unit

// file: phyei_regs.svh
// Register offsets, field positions and reset values of the event unit
`ifndef PHYEI_REGS_SVH
`define PHYEI_REGS_SVH

`define PHYEI_MASK_OFS   5'h19
`define PHYEI_STAT_OFS   5'h1A
`define PHYEI_MASK_RST   16'h0000
`define PHYEI_STAT_RST   15'h0000
`define PHYEI_RDATA_RST  16'h0000
`define PHYEI_SUM_BIT    15
`define PHYEI_SPD_BIT    14
`define PHYEI_LNK_BIT    13
`define PHYEI_DPX_BIT    12
`define PHYEI_RSV_BIT    6
`define PHYEI_DSH_BIT    2
`define PHYEI_RXE_BIT    0
`define PHYEI_NUM_EVT    15

`endif

// file: phyei_pkg.sv
// Types shared by the event unit and its users
package phyei_pkg;

	// Raw event pulses, bit 14 down to bit 0 of the status word
	typedef struct packed {
		logic speed_chg;
		logic link_chg;
		logic full_duplex_chg;
		logic an_err;
		logic an_done;
		logic pd_detect;
		logic symbol_err;
		logic fast_link_fail;
		logic rsvd;
		logic ext;
		logic auto_media_sense_chg;
		logic false_carrier;
		logic downshift;
		logic ms_res_err;
		logic rx_err;
	} phyei_evt_t;

	// One management register access, decoded from the serial interface
	typedef struct packed {
		logic [4:0]  addr;
		logic        rd;
		logic        wr;
		logic [15:0] wdata;
	} phyei_req_t;

	// Levels from other PHY registers that qualify events or resets
	typedef struct packed {
		logic       an_enable;
		logic [3:0] adv_8_5;
		logic       rx_er_cext;
		logic       sticky_rst_en;
		logic       sw_reset;
	} phyei_ctl_t;

	// Register state of the top module, apart from status bits 14..0
	typedef struct packed {
		logic [15:0] mask;
		logic        summary;
		logic [15:0] rdata;
		logic        rvalid;
		logic        pin_oe;
		logic        pin_lvl;
	} phyei_state_t;

endpackage

// file: phyei_latch.sv
// One sticky event flag: set wins over clear
`timescale 1ns/1ps

module phyei_latch (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic clk_en,
	input  wire logic set,
	input  wire logic clr,
	output logic      q_r
);

	logic q_nxt;

	always_comb begin
		q_nxt = q_r;
		if (clr) begin
			q_nxt = 1'b0;
		end
		if (set) begin
			q_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q_r <= 1'b0;
		end else if (clk_en) begin
			q_r <= q_nxt;
		end
	end

endmodule // phyei_latch

// file: phyei_host.sv
// Management host model: register accesses over the decoded port
`timescale 1ns/1ps

module phyei_host (
	input  wire logic            core_clk,
	output phyei_pkg::phyei_req_t req
);
	initial req = '0;

	// One access, held over one rising edge, then lines scrambled
	task automatic acc(input logic [4:0] a, input logic r, input logic w,
		input logic [15:0] d);
		@(negedge core_clk);
		req = '{a, r, w, d};
		@(negedge core_clk);
		req = '{~a, 1'b0, 1'b0, ~d};
	endtask

	// Status read first so stale events cannot raise the pin
	task automatic arm(input logic [15:0] m);
		acc(5'h1A, 1'b1, 1'b0, 16'h0000);
		acc(5'h19, 1'b0, 1'b1, m);
	endtask
endmodule // phyei_host

// file: testbench.sv
// Self-checking bench of the event interrupt unit
`timescale 1ns/1ps

module testbench;
	logic                  core_clk;
	logic                  nrst;
	logic                  clk_en;
	phyei_pkg::phyei_evt_t evt;
	phyei_pkg::phyei_ctl_t ctl;
	phyei_pkg::phyei_req_t req;
	logic [15:0]           rdata;
	logic                  rvalid;
	logic                  pin_o;
	logic                  pin_oe;
	logic [15:0]           exp_q[$];
	logic [31:0]           seed;
	int                    miscompares;
	int                    checks_done;
	int                    cycles;

	phyei_unit dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.evt(evt), .ctl(ctl), .req(req),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
		.mgmt_interrupt_pin(pin_o), .mgmt_interrupt_pin_oe(pin_oe));
	phyei_host host (.core_clk(core_clk), .req(req));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t read %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic e);
		checks_done++;
		if ({pin_o, pin_oe} !== {1'b0, e}) begin
			miscompares++;
			$display("[ERR] %0t pin oe %b exp %b", $time, pin_oe, e);
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.acc(a, 1'b1, 1'b0, 16'h0000);
	endtask

	task automatic pulse(input logic [14:0] e);
		@(negedge core_clk);
		evt = e;
		@(negedge core_clk);
		evt = '0;
	endtask

	task automatic swr(input logic s);
		@(negedge core_clk);
		ctl.sticky_rst_en = s;
		ctl.sw_reset = 1'b1;
		@(negedge core_clk);
		ctl.sw_reset = 1'b0;
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			wrap_up();
		end
	end

	// Oldest noted read result against each returned word
	always @(negedge core_clk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() > 0)
				cmp16(rdata, exp_q.pop_front());
			else begin
				miscompares++;
				$display("[ERR] %0t unexpected read", $time);
			end
		end
	end

	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		evt = '0;
		ctl = '{1'b1, 4'hF, 1'b0, 1'b1, 1'b0};
		seed = 32'h50B4CBC6;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		chk_pin(1'b0);
		rd(5'h19, 16'h0000);
		rd(5'h1A, 16'h0000);
		repeat (8) begin
			seed = xs(seed);
			host.acc(5'h19, 1'b0, 1'b1, seed[15:0]);
			rd(5'h19, seed[15:0]);
		end
		host.acc(5'h19, 1'b0, 1'b1, 16'h7FFF);
		pulse(15'h7FFF);
		chk_pin(1'b0);
		rd(5'h1A, 16'hFFBF);
		rd(5'h1A, 16'h0000);
		ctl = '{1'b0, 4'hE, 1'b1, 1'b1, 1'b0};
		pulse(15'h7FFF);
		rd(5'h1A, 16'hAFBA);
		ctl = '{1'b1, 4'hF, 1'b0, 1'b1, 1'b0};
		host.acc(5'h19, 1'b0, 1'b1, 16'h2000);
		pulse(15'h7FFF);
		rd(5'h1A, 16'hA000);
		exp_q.push_back(16'h0000);
		host.arm(16'hA000);
		pulse(15'h2000);
		chk_pin(1'b1);
		rd(5'h1A, 16'hA000);
		chk_pin(1'b0);
		host.acc(5'h19, 1'b0, 1'b1, 16'h2000);
		pulse(15'h2000);
		chk_pin(1'b0);
		host.acc(5'h19, 1'b0, 1'b1, 16'hA000);
		chk_pin(1'b1);
		rd(5'h1A, 16'hA000);
		chk_pin(1'b0);
		pulse(15'h2000);
		swr(1'b1);
		chk_pin(1'b0);
		rd(5'h19, 16'hA000);
		rd(5'h1A, 16'h0000);
		swr(1'b0);
		rd(5'h19, 16'h0000);
		// Frozen clock enable: no event latches, no read is taken
		host.acc(5'h19, 1'b0, 1'b1, 16'h2000);
		@(negedge core_clk);
		clk_en = 1'b0;
		pulse(15'h2000);
		host.acc(5'h1A, 1'b1, 1'b0, 16'h0000);
		@(negedge core_clk);
		clk_en = 1'b1;
		rd(5'h1A, 16'h0000);
		pulse(15'h2000);
		rd(5'h1A, 16'hA000);
		repeat (2) @(negedge core_clk);
		cmp16(16'(exp_q.size()), 16'h0000);
		wrap_up();
	end
endmodule // testbench
